/* shared/tcc_pkg.sv */
// Shared constants and types of the timer capture/compare channel block
`default_nettype none
package tcc_pkg;
  // Register offsets
  localparam logic [3:0] TCC_CTRL_BASE = 4'h0;
  localparam logic [3:0] TCC_VAL_BASE = 4'h4;
  localparam logic [3:0] TCC_STATUS_ADDR = 4'hC;
  localparam logic [3:0] TCC_MASK_ADDR = 4'hD;
  // Channel control field positions
  localparam int TCC_BUF_BIT = 5;
  localparam int TCC_MODE_A_BIT = 4;
  localparam int TCC_ELS_LSB = 2;
  // Status bit of the overflow event
  localparam int TCC_OVF_BIT = 4;
  // Writable control bits and reset values
  localparam logic [7:0] TCC_CTRL_WMASK = 8'h3C;
  localparam logic [7:0] TCC_CTRL_RST = 8'h00;
  localparam logic [15:0] TCC_VAL_RST = 16'h0000;
  localparam logic [4:0] TCC_STATUS_RST = 5'h00;
  localparam logic [4:0] TCC_MASK_RST = 5'h00;
  localparam logic [7:0] TCC_RD_IDLE = 8'h00;

  // Edge/level select: capture edge or compare action
  typedef enum logic [1:0] {
    TCC_ELS_OFF = 2'h0,   // Capture off / pin not driven
    TCC_ELS_A = 2'h1,     // Rising edge / toggle
    TCC_ELS_B = 2'h2,     // Falling edge / clear
    TCC_ELS_AB = 2'h3     // Both edges / set
  } tcc_els_e;

  // Buffered select overrides mode A; either means compare
  function automatic logic tcc_is_compare(input logic [7:0] c);
    return c[TCC_BUF_BIT] | c[TCC_MODE_A_BIT];
  endfunction : tcc_is_compare

  // Edge/level field of a control byte
  function automatic tcc_els_e tcc_els(input logic [7:0] c);
    return tcc_els_e'(c[TCC_ELS_LSB +: 2]);
  endfunction : tcc_els
endpackage : tcc_pkg
`default_nettype wire

/* design/tcc_chan.sv */
// One capture/compare channel: edge detect, compare match, pin level
`default_nettype none
module tcc_chan #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  input wire logic [CNT_W-1:0] count_in,
  input wire logic count_step_in,
  input wire logic cap_en_in,
  input wire logic cmp_en_in,
  input wire logic [1:0] els_in,
  input wire logic [CNT_W-1:0] cmp_val_in,
  output logic capture_out,
  output logic match_out,
  output logic pin_out
);
  typedef struct packed {
    logic primed;
    logic prev_pin;
    logic level;
  } tcc_chan_s;

  tcc_chan_s r;
  tcc_chan_s next_r;
  logic rise;
  logic fall;

  // Edge detect, primed after reset so a high pin is no edge
  always_comb begin
    rise = r.primed && !r.prev_pin && pin_in;
    fall = r.primed && r.prev_pin && !pin_in;
    capture_out = 1'b0;
    if (cap_en_in) begin
      case (tcc_pkg::tcc_els_e'(els_in))
        tcc_pkg::TCC_ELS_A: capture_out = rise;
        tcc_pkg::TCC_ELS_B: capture_out = fall;
        tcc_pkg::TCC_ELS_AB: capture_out = rise | fall;
        default: capture_out = 1'b0;
      endcase
    end
    // Full 16-bit equality, once per counter step
    match_out = cmp_en_in && count_step_in && (count_in == cmp_val_in);
  end

  // Pin action on match
  always_comb begin
    next_r = r;
    next_r.primed = 1'b1;
    next_r.prev_pin = pin_in;
    if (match_out) begin
      case (tcc_pkg::tcc_els_e'(els_in))
        tcc_pkg::TCC_ELS_A: next_r.level = !r.level;
        tcc_pkg::TCC_ELS_B: next_r.level = 1'b0;
        tcc_pkg::TCC_ELS_AB: next_r.level = 1'b1;
        default: next_r.level = r.level;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pin_out = r.level;
endmodule : tcc_chan
`default_nettype wire

/* design/tcc_top.sv */
// Four-channel timer capture/compare block with buffered channel pairs
//
// Local design decisions: the address-and-strobe port and the register offsets.
`default_nettype none
module tcc_top #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rd_data_out,
  input wire logic [CNT_W-1:0] counter_in,
  input wire logic count_step_in,
  input wire logic overflow_in,
  input wire logic chan0_pin_in,
  output logic chan0_pin_out,
  output logic chan0_pin_oe_n_out,
  input wire logic chan1_pin_in,
  output logic chan1_pin_out,
  output logic chan1_pin_oe_n_out,
  input wire logic chan2_pin_in,
  output logic chan2_pin_out,
  output logic chan2_pin_oe_n_out,
  input wire logic chan3_pin_in,
  output logic chan3_pin_out,
  output logic chan3_pin_oe_n_out,
  output logic irq_out
);
  typedef struct packed {
    logic [3:0][7:0] ctrl;
    logic [3:0][CNT_W-1:0] val;
    logic [4:0] status;
    logic [4:0] mask;
    logic [1:0] last_wr;
    logic [1:0] active;
    logic [7:0] rd_data;
  } tcc_regs_s;

  tcc_regs_s r;
  tcc_regs_s next_r;
  logic [1:0] linked;
  logic [3:0] cap_en;
  logic [3:0] cmp_en;
  logic [3:0][1:0] els;
  logic [3:0][CNT_W-1:0] cmp_val;
  logic [3:0] cap;
  logic [3:0] mat;
  logic [3:0] lvl;
  logic [3:0] oe_n;
  logic [3:0] pins;

  // Value byte address decode: channel index and high-byte flag
  function automatic logic [2:0] val_decode(input logic [3:0] a);
    logic [3:0] off;
    off = a - tcc_pkg::TCC_VAL_BASE;
    return {off[2:1], !off[0]};
  endfunction : val_decode

  assign pins = {chan3_pin_in, chan2_pin_in, chan1_pin_in, chan0_pin_in};

  // Pair links from channel 0 and channel 2 buffer bits
  assign linked[0] = r.ctrl[0][tcc_pkg::TCC_BUF_BIT];
  assign linked[1] = r.ctrl[2][tcc_pkg::TCC_BUF_BIT];

  // Effective channel configuration
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      logic dead;
      dead = (i == 1 && linked[0]) || (i == 3 && linked[1]);
      els[i] = r.ctrl[i][tcc_pkg::TCC_ELS_LSB +: 2];
      cmp_en[i] = !dead && tcc_pkg::tcc_is_compare(r.ctrl[i]);
      cap_en[i] = !dead && !cmp_en[i] && (els[i] != 2'(tcc_pkg::TCC_ELS_OFF));
      // Linked pair: active set picks the compare value
      if (i % 2 == 0 && linked[i / 2] && r.active[i / 2]) begin
        cmp_val[i] = r.val[i | 1];
      end else begin
        cmp_val[i] = r.val[i];
      end
      // Released or input pins are never driven
      oe_n[i] = !(cmp_en[i] && (els[i] != 2'(tcc_pkg::TCC_ELS_OFF)));
    end
  end

  // Channel units
  for (genvar g = 0; g < 4; g++) begin : g_chan
    tcc_chan #(.CNT_W(CNT_W)) u_chan (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .pin_in(pins[g]),
      .count_in(counter_in),
      .count_step_in(count_step_in),
      .cap_en_in(cap_en[g]),
      .cmp_en_in(cmp_en[g]),
      .els_in(els[g]),
      .cmp_val_in(cmp_val[g]),
      .capture_out(cap[g]),
      .match_out(mat[g]),
      .pin_out(lvl[g])
    );
  end

  // Register writes, captures, flags, pair swap and reads
  always_comb begin
    logic [2:0] vd;
    logic [4:0] set;
    logic [4:0] clr;
    next_r = r;
    vd = val_decode(addr_in);
    set = '0;
    clr = '0;
    next_r.rd_data = tcc_pkg::TCC_RD_IDLE;
    // Register writes
    if (wr_in) begin
      if (addr_in < tcc_pkg::TCC_VAL_BASE) begin
        next_r.ctrl[addr_in[1:0]] = wr_data_in & tcc_pkg::TCC_CTRL_WMASK;
        if (addr_in[0]) begin
          next_r.ctrl[addr_in[1:0]][tcc_pkg::TCC_BUF_BIT] = 1'b0;
        end
      end else if (addr_in < tcc_pkg::TCC_STATUS_ADDR) begin
        if (vd[0]) begin
          next_r.val[vd[2:1]][15:8] = wr_data_in;
        end else begin
          next_r.val[vd[2:1]][7:0] = wr_data_in;
        end
        next_r.last_wr[vd[2]] = vd[1];
      end else if (addr_in == tcc_pkg::TCC_STATUS_ADDR) begin
        clr = wr_data_in[4:0];
      end else if (addr_in == tcc_pkg::TCC_MASK_ADDR) begin
        next_r.mask = wr_data_in[4:0];
      end
    end
    // Captures win over a write in the same cycle
    for (int i = 0; i < 4; i++) begin
      if (cap[i]) begin
        next_r.val[i] = counter_in;
      end
      set[i] = cap[i] | mat[i];
    end
    set[tcc_pkg::TCC_OVF_BIT] = overflow_in;
    // Set wins over write-one clear
    next_r.status = (r.status & ~clr) | set;
    // Overflow hands control to the last written set
    for (int p = 0; p < 2; p++) begin
      if (!linked[p]) begin
        next_r.active[p] = 1'b0;
        next_r.last_wr[p] = 1'b0;
      end else if (overflow_in) begin
        next_r.active[p] = r.last_wr[p];
      end
    end
    // Read data for the next cycle
    if (rd_in) begin
      if (addr_in < tcc_pkg::TCC_VAL_BASE) begin
        next_r.rd_data = r.ctrl[addr_in[1:0]];
      end else if (addr_in < tcc_pkg::TCC_STATUS_ADDR) begin
        next_r.rd_data = vd[0] ? r.val[vd[2:1]][15:8] : r.val[vd[2:1]][7:0];
      end else if (addr_in == tcc_pkg::TCC_STATUS_ADDR) begin
        next_r.rd_data = {3'h0, r.status};
      end else if (addr_in == tcc_pkg::TCC_MASK_ADDR) begin
        next_r.rd_data = {3'h0, r.mask};
      end else begin
        next_r.rd_data = tcc_pkg::TCC_RD_IDLE;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      r.ctrl <= {4{tcc_pkg::TCC_CTRL_RST}};
      r.val <= {4{tcc_pkg::TCC_VAL_RST}};
      r.status <= tcc_pkg::TCC_STATUS_RST;
      r.mask <= tcc_pkg::TCC_MASK_RST;
      r.last_wr <= 2'h0;
      r.active <= 2'h0;
      r.rd_data <= tcc_pkg::TCC_RD_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Outputs
  assign rd_data_out = r.rd_data;
  assign irq_out = |(r.status & r.mask);
  assign chan0_pin_out = lvl[0];
  assign chan1_pin_out = lvl[1];
  assign chan2_pin_out = lvl[2];
  assign chan3_pin_out = lvl[3];
  assign chan0_pin_oe_n_out = oe_n[0];
  assign chan1_pin_oe_n_out = oe_n[1];
  assign chan2_pin_oe_n_out = oe_n[2];
  assign chan3_pin_oe_n_out = oe_n[3];

  // Checks
  a_capture_latch: assert property (@(posedge core_clk_in) disable iff (reset_in)
    cap[0] |=> r.val[0] == $past(counter_in))
    else $error("capture did not latch counter");

  a_rise_capture: assert property (@(posedge core_clk_in) disable iff (reset_in)
    cap_en[1] && els[1] == 2'h1 && $past(chan1_pin_in) == 1'b0 && chan1_pin_in && !$rose(reset_in)
      && $past(cap_en[1]) |-> cap[1])
    else $error("rising edge missed");

  a_cap_irq: assert property (@(posedge core_clk_in) disable iff (reset_in)
    cap[2] && r.mask[2] |=> irq_out && r.status[2])
    else $error("capture interrupt missing");

  a_compare_set: assert property (@(posedge core_clk_in) disable iff (reset_in)
    mat[0] && els[0] == 2'h3 |=> chan0_pin_out)
    else $error("set on compare failed");

  a_compare_clear: assert property (@(posedge core_clk_in) disable iff (reset_in)
    mat[2] && els[2] == 2'h2 |=> !chan2_pin_out)
    else $error("clear on compare failed");

  a_match_irq: assert property (@(posedge core_clk_in) disable iff (reset_in)
    mat[3] && r.mask[3] |=> irq_out)
    else $error("compare interrupt missing");

  a_unbuf_write: assert property (@(posedge core_clk_in) disable iff (reset_in)
    wr_in && addr_in == 4'h5 && !cap[0] |=> r.val[0][7:0] == $past(wr_data_in))
    else $error("low byte write not taken");

  a_match_equal: assert property (@(posedge core_clk_in) disable iff (reset_in)
    mat[1] |-> counter_in == r.val[1] && count_step_in)
    else $error("match without equality");

  a_ovf_flag: assert property (@(posedge core_clk_in) disable iff (reset_in)
    overflow_in |=> r.status[4])
    else $error("overflow flag not set");

  a_pair_swap: assert property (@(posedge core_clk_in) disable iff (reset_in)
    linked[0] && overflow_in && !wr_in ##1 linked[0] |-> r.active[0] == $past(r.last_wr[0]))
    else $error("pair did not take last written set");

  a_pair_start: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !linked[1] |=> !r.active[1] || $past(overflow_in))
    else $error("pair 2/3 did not start on channel 2");

  a_second_dead: assert property (@(posedge core_clk_in) disable iff (reset_in)
    linked[0] |-> !cap[1] && !mat[1])
    else $error("second channel active while linked");

  a_pin_release: assert property (@(posedge core_clk_in) disable iff (reset_in)
    linked[1] |-> chan3_pin_oe_n_out)
    else $error("released pin still driven");

  a_buf_override: assert property (@(posedge core_clk_in) disable iff (reset_in)
    r.ctrl[2][5] && els[2] != 2'h0 |-> !chan2_pin_oe_n_out && !cap_en[2])
    else $error("buffer bit did not select compare");
endmodule : tcc_top
`default_nettype wire

/* verification/tcc_pin_model.sv */
// Pin load and external event source for one channel pin
`default_nettype none
module tcc_pin_model (
  input wire logic oe_n_in,
  input wire logic drive_in,
  input wire logic source_in,
  output logic level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released pin belongs to the event source again
  assign level_out = oe_n_in ? source_in : drive_in;
endmodule : tcc_pin_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench of the capture/compare block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, wr, rd, step, ovf, irq;
  logic [3:0] addr, src;
  wire logic [3:0] lvl, pout, oen;
  logic [7:0] wdat, rdat;
  logic [15:0] cnt;
  logic [7:0] acts [4] = '{8'h1C, 8'h18, 8'h14, 8'h14};
  logic exps [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic prev;
  int fail_count, checked, f;

  tcc_top i_dut (.core_clk_in(clk), .reset_in(rst), .addr_in(addr), .wr_data_in(wdat), .wr_in(wr),
    .rd_in(rd), .rd_data_out(rdat), .counter_in(cnt), .count_step_in(step), .overflow_in(ovf),
    .chan0_pin_in(lvl[0]), .chan0_pin_out(pout[0]), .chan0_pin_oe_n_out(oen[0]),
    .chan1_pin_in(lvl[1]), .chan1_pin_out(pout[1]), .chan1_pin_oe_n_out(oen[1]),
    .chan2_pin_in(lvl[2]), .chan2_pin_out(pout[2]), .chan2_pin_oe_n_out(oen[2]),
    .chan3_pin_in(lvl[3]), .chan3_pin_out(pout[3]), .chan3_pin_oe_n_out(oen[3]), .irq_out(irq));

  // One load model per channel pin
  for (genvar i = 0; i < 4; i++) begin : g_pin
    tcc_pin_model i_pin (.oe_n_in(oen[i]), .drive_in(pout[i]), .source_in(src[i]), .level_out(lvl[i]));
  end

  // Clock, 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask : chkb

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask : wr_reg

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(what, exp, rdat);
  endtask : rd_chk

  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr_reg(a, v[15:8]);
    wr_reg(a + 4'h1, v[7:0]);
  endtask : wr16

  // One fresh counter step; result lands at the following edge
  task automatic step_to(input logic [15:0] v);
    @(posedge clk);
    cnt <= v;
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
    @(negedge clk);
  endtask : step_to

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    {rst, wr, rd, step, ovf} = 5'h10;
    {addr, src, wdat, cnt} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (acts[i]) rd_chk("reset reg", 4'(i), 8'h00);
    rd_chk("unmapped", 4'hE, 8'h00);
    chk("reset oe_n", 8'h0F, {4'h0, oen});
    chk("reset pin_out", 8'h00, {4'h0, pout});
    // Rising capture on channel 0, interrupt gated by mask
    wr_reg(4'h0, 8'h04);
    @(posedge clk);
    cnt <= 16'h1234;
    src[0] <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("cap0 hi", 4'h4, 8'h12);
    rd_chk("cap0 lo", 4'h5, 8'h34);
    rd_chk("status cap0", 4'hC, 8'h01);
    chkb("irq masked", 1'b0, irq);
    wr_reg(4'hD, 8'h01);
    chkb("irq", 1'b1, irq);
    wr_reg(4'hC, 8'h01);
    chkb("irq cleared", 1'b0, irq);
    // Falling capture on channel 1 ignores the rising edge
    wr_reg(4'h1, 8'h08);
    @(posedge clk);
    cnt <= 16'h1111;
    src[1] <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("no rise cap1", 4'hC, 8'h00);
    @(posedge clk);
    cnt <= 16'h2222;
    src[1] <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk("cap1 hi", 4'h6, 8'h22);
    rd_chk("status cap1", 4'hC, 8'h02);
    // Compare actions on channel 2, partial match rejected
    wr16(4'h8, 16'h0100);
    prev = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr_reg(4'h2, acts[i]);
      step_to(16'h0200);
      chkb("pin2 hold", prev, pout[2]);
      step_to(16'h0100);
      chkb("pin2 action", exps[i], pout[2]);
      prev = exps[i];
    end
    chkb("pin2 oe_n", 1'b0, oen[2]);
    rd_chk("status cmp2", 4'hC, 8'h06);
    // Unbuffered rewrite below a passed count skips the period
    wr_reg(4'h3, 8'h1C);
    wr16(4'hA, 16'h0050);
    step_to(16'h0030);
    wr16(4'hA, 16'h0020);
    step_to(16'h0040);
    step_to(16'h0050);
    chkb("pin3 old value", 1'b0, pout[3]);
    step_to(16'h0020);
    chkb("pin3 new value", 1'b1, pout[3]);
    wr_reg(4'h3, 8'h00);
    wr_reg(4'hC, 8'h1F);
    // Both-edge capture on channel 3
    wr_reg(4'h3, 8'h0C);
    @(posedge clk);
    cnt <= 16'h3344;
    src[3] <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk("cap3 rise hi", 4'hA, 8'h33);
    @(posedge clk);
    cnt <= 16'h5566;
    src[3] <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk("cap3 fall lo", 4'hB, 8'h66);
    rd_chk("status cap3", 4'hC, 8'h08);
    wr_reg(4'h3, 8'h00);
    wr_reg(4'hC, 8'h1F);
    // Buffered pairs 0/1 then 2/3
    for (int p = 0; p < 2; p++) begin
      f = 2 * p;
      wr_reg(4'(f), 8'h24);
      wr_reg(4'(f + 1), 8'h1C);
      wr16(4'(4 + 4 * p), 16'h0010);
      wr16(4'(6 + 4 * p), 16'h0020);
      chkb("second oe_n", 1'b1, oen[f + 1]);
      step_to(16'h0020);
      chkb("first set rules", 1'b0, pout[f]);
      step_to(16'h0010);
      chkb("first match", 1'b1, pout[f]);
      @(posedge clk);
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      step_to(16'h0010);
      chkb("old set retired", 1'b1, pout[f]);
      step_to(16'h0020);
      chkb("second match", 1'b0, pout[f]);
      rd_chk("status pair", 4'hC, p == 0 ? 8'h11 : 8'h15);
      wr_reg(4'hC, 8'h1F);
    end
    complete_run();
  end
endmodule : tb
`default_nettype wire
